//--- src/lpar_pkg.sv
// ********************************
// Shared constants and types
// ********************************
package lpar_pkg;
  localparam int NBANK   = 4;
  localparam int BA_W    = 2;
  localparam int ADDR_W  = 13;
  localparam int DQ_W    = 16;
  localparam int AP_BIT  = 10;  // Auto-precharge / all-banks address bit
  localparam int CNT_W   = 6;   // Width of spacing counters, in link cycles
  localparam int CK_HALF = 4;   // clk cycles per link clock half period
  // Minimum spacings, in link clock cycles
  localparam int T_RCD   = 3;
  localparam int T_RC    = 10;
  localparam int T_RRD   = 2;
  localparam int T_RP    = 3;
  localparam int T_RAS   = 7;
  // Counters leave reset saturated so no spacing is pending
  localparam logic [CNT_W-1:0] CNT_RST = 6'h3f;
  localparam logic [1:0] CL3 = 2'h3;

  // Command code is {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_PRE        = 3'b010,
    CMD_ACT        = 3'b011,
    CMD_WRITE      = 3'b100,
    CMD_READ       = 3'b101,
    CMD_BURST_STOP = 3'b110,
    CMD_NOP        = 3'b111
  } lpar_cmd_t;

  // One entry of the read latency pipeline
  typedef struct packed {
    logic              v;
    logic              rd;
    logic              ap;
    logic              any;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] col;
  } lpar_ent_t;

  // Burst length select 0..3 gives 2, 4, 8, 16
  function automatic logic [4:0] bl_len(input logic [1:0] sel);
    bl_len = 5'h02 << sel;
  endfunction
endpackage

//--- src/lpar_if.sv
`timescale 1ns/1ps
// ********************************
// Link between controller and memory
// ********************************
interface lpar_if import lpar_pkg::*; #(
  parameter int W = DQ_W
) ();
  localparam int NB = W / 8;
  logic              ck;
  lpar_cmd_t         cmd;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic [W-1:0]      dq_out;
  logic              dq_oe;
  logic [W-1:0]      dq;
  logic [NB-1:0]     dqs_out;
  logic [NB-1:0]     dqs_oe;
  logic [NB-1:0]     dqs;

  // Wire level; an undriven bus reads low here
  assign dq  = dq_oe ? dq_out : '0;
  assign dqs = dqs_oe & dqs_out;

  modport dev (input ck, cmd, ba, addr, output dq_out, dq_oe, dqs_out, dqs_oe);
  modport ctl (output ck, cmd, ba, addr, input dq, dqs);
endinterface

//--- src/lpar_buf2.sv
`timescale 1ns/1ps
// ********************************
// Small read data buffer
// ********************************
module lpar_buf2 #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [PW:0]   cnt;
  logic          push;
  logic          pop;

  // Depth must be a power of two for the pointer wrap
  assign in_ready  = cnt != (PW+1)'(DEPTH);
  assign out_valid = cnt != '0;
  assign out_data  = mem[rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // lpar_buf2

//--- src/lpar_ctl.sv
`timescale 1ns/1ps
// ********************************
// Controller end: clock, commands, capture
// ********************************
module lpar_ctl import lpar_pkg::*; #(
  parameter int W    = DQ_W,
  parameter int HALF = CK_HALF,
  parameter int RCD  = T_RCD,
  parameter int RC   = T_RC,
  parameter int RRD  = T_RRD,
  parameter int RP   = T_RP,
  parameter int RAS  = T_RAS
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [1:0]        cas_lat,
  input  wire logic [1:0]        bl_sel,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire lpar_cmd_t         req_cmd,
  input  wire logic [BA_W-1:0]   req_ba,
  input  wire logic [ADDR_W-1:0] req_addr,
  output logic                   req_reject,
  output logic                   rd_valid,
  input  wire logic              rd_ready,
  output logic [2*W-1:0]         rd_data,
  output logic                   rd_overrun,
  lpar_if.ctl                    link
);
  logic [7:0]        div;
  logic              ck_q;
  logic              t_rise;
  logic              t_fall;
  lpar_cmd_t         cmd_q;
  logic [BA_W-1:0]   ba_q;
  logic [ADDR_W-1:0] addr_q;
  logic [NBANK-1:0]  open_v;
  logic [NBANK-1:0]  apw_v;
  logic [CNT_W-1:0]  sa_v [NBANK];
  logic [CNT_W-1:0]  sp_v [NBANK];
  logic [CNT_W-1:0]  rrd;
  logic [CNT_W-1:0]  rbusy;
  logic [4:0]        half;
  logic              ok;
  logic              closed_rw;
  logic              go;
  logic [W:0]        cap1;
  logic [W:0]        cap2;
  logic              dqs_d;
  logic [W-1:0]      lo;
  logic              push;
  logic              in_ready;

  assign half = bl_len(bl_sel) >> 1;

  // ********************************
  // Link clock divider
  // ********************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div  <= '0;
      ck_q <= 1'b0;
    end else if (div == 8'(HALF - 1)) begin
      div  <= '0;
      ck_q <= ~ck_q;
    end else begin
      div <= div + 8'h01;
    end
  end
  assign t_rise = (div == 8'(HALF - 1)) & ~ck_q;
  assign t_fall = (div == 8'(HALF - 1)) & ck_q;

  // ********************************
  // Spacing checks on the request
  // ********************************
  // Commands leave on the falling edge so they are stable at the rise
  always_comb begin
    closed_rw = ((req_cmd == CMD_READ) | (req_cmd == CMD_WRITE)) & ~open_v[req_ba];
    case (req_cmd)
      CMD_ACT:   ok = ~open_v[req_ba] & (sa_v[req_ba] >= CNT_W'(RC)) & (rrd >= CNT_W'(RRD))
                    & (sp_v[req_ba] >= (apw_v[req_ba] ? CNT_W'(RP + RAS) + CNT_W'(half)
                    : CNT_W'(RP)));
      CMD_READ:  ok = (sa_v[req_ba] >= CNT_W'(RCD)) & in_ready;
      CMD_WRITE: ok = (sa_v[req_ba] >= CNT_W'(RCD)) & (rbusy == '0);
      CMD_PRE:   ok = (sa_v[req_ba] >= CNT_W'(RAS)) | req_addr[AP_BIT];
      default:   ok = 1'b1;
    endcase
  end
  // A read or write to a closed bank is taken and dropped, never sent
  assign req_ready  = t_fall & (ok | closed_rw);
  assign req_reject = req_valid & req_ready & closed_rw;
  assign go         = req_valid & req_ready & ~closed_rw;

  // Command pins, NOP when nothing is taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_q  <= CMD_NOP;
      ba_q   <= '0;
      addr_q <= '0;
    end else if (t_fall) begin
      cmd_q  <= go ? req_cmd : CMD_NOP;
      ba_q   <= req_ba;
      addr_q <= req_addr;
    end
  end
  assign link.ck   = ck_q;
  assign link.cmd  = cmd_q;
  assign link.ba   = ba_q;
  assign link.addr = addr_q;

  // ********************************
  // Per-bank state and spacing counters
  // ********************************
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic hit;
    assign hit = go & (req_ba == BA_W'(b));
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        open_v[b] <= 1'b0;
        apw_v[b]  <= 1'b0;
        sa_v[b]   <= CNT_RST;
        sp_v[b]   <= CNT_RST;
      end else if (t_rise) begin
        sa_v[b] <= (&sa_v[b]) ? sa_v[b] : sa_v[b] + 1'b1;
        sp_v[b] <= (&sp_v[b]) ? sp_v[b] : sp_v[b] + 1'b1;
      end else if (t_fall) begin
        if (hit & (req_cmd == CMD_ACT)) begin
          open_v[b] <= 1'b1;
          apw_v[b]  <= 1'b0;
          sa_v[b]   <= '0;
        end
        // Auto-precharge closes the row on its own; wait covers that
        if ((hit & (req_cmd == CMD_READ) & req_addr[AP_BIT])
            | (go & (req_cmd == CMD_PRE) & (hit | req_addr[AP_BIT]))) begin
          open_v[b] <= 1'b0;
          apw_v[b]  <= req_cmd == CMD_READ;
          sp_v[b]   <= '0;
        end
      end
    end
  end

  // Bank-to-bank activate spacing and read-in-flight window
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rrd   <= CNT_RST;
      rbusy <= '0;
    end else if (t_rise) begin
      rrd   <= (&rrd) ? rrd : rrd + 1'b1;
      rbusy <= (rbusy == '0) ? rbusy : rbusy - 1'b1;
    end else if (t_fall & go) begin
      if (req_cmd == CMD_ACT) begin
        rrd <= '0;
      end
      if (req_cmd == CMD_READ) begin
        rbusy <= CNT_W'(cas_lat) + CNT_W'(half) + CNT_W'(1);
      end else if (req_cmd == CMD_BURST_STOP) begin
        rbusy <= CNT_W'(cas_lat) + CNT_W'(1);
      end
    end
  end

  // ********************************
  // Read capture on strobe edges
  // ********************************
  // Data and strobe change together and stay put a whole half period
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cap1       <= '0;
      cap2       <= '0;
      dqs_d      <= 1'b0;
      lo         <= '0;
      rd_overrun <= 1'b0;
    end else begin
      cap1  <= {link.dqs[0], link.dq};
      cap2  <= cap1;
      dqs_d <= cap2[W];
      if (cap2[W] & ~dqs_d) begin
        lo <= cap2[W-1:0];
      end
      if (push & ~in_ready) begin
        rd_overrun <= 1'b1;
      end
    end
  end
  assign push = ~cap2[W] & dqs_d;

  lpar_buf2 #(.W(2*W), .DEPTH(2)) u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   ({cap2[W-1:0], lo}),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );
endmodule // lpar_ctl

//--- src/lpar_dev.sv
`timescale 1ns/1ps
// ********************************
// Memory end: banks and read bursts
// ********************************
// Summary of operation
// - Controller activates a row before any access
// - Access waits activate-to-access spacing
// - Same-bank reactivate needs precharge, cycle spacing
// - Other-bank activates allowed, bank-to-bank spacing
// - Read carries column, bank, auto-precharge choice
// - First element after latency, then every edge
// - Strobe with data, low preamble and postamble
// - Data pins released after burst ends
// - Read, write, stop, precharge cut bursts
// - Next read after wanted pairs streams seamlessly
// - Read accepted on any cycle after read
// - Burst stop acts after the read latency
// - Write only after burst done or stopped
// - Length two may use NOP before write
// - Precharge may cut burst, then precharge wait
// - Auto-precharge starts half a burst later
// - Reads two apart: length four concatenates
// - Reads every cycle cut bursts over two
// - One strobe per data byte
// - Read latency two or three cycles
module lpar_dev import lpar_pkg::*; #(
  parameter int W   = DQ_W,
  parameter int RCD = T_RCD,
  parameter int RC  = T_RC,
  parameter int RRD = T_RRD,
  parameter int RP  = T_RP,
  parameter int RAS = T_RAS
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] cas_lat,
  input  wire logic [1:0] bl_sel,
  lpar_if.dev             link,
  output logic [NBANK-1:0] bank_open,
  output logic            proto_err
);
  localparam int NB = W / 8;
  localparam int SW = 1 + 3 + BA_W + ADDR_W;
  logic [SW-1:0]     sync1;
  logic [SW-1:0]     sync2;
  logic              ck_d;
  logic              ck_s;
  logic              rise;
  logic              fall;
  lpar_cmd_t         cmd_s;
  logic [BA_W-1:0]   ba_s;
  logic [ADDR_W-1:0] addr_s;
  logic [4:0]        bl;
  logic [3:0]        mask;
  logic [CNT_W-1:0]  rrd;
  logic [NBANK-1:0]  bk_err;
  logic [ADDR_W-1:0] bk_row [NBANK];
  lpar_ent_t         cur;
  lpar_ent_t         dl1;
  lpar_ent_t         dl2;
  lpar_ent_t         st_e;
  lpar_ent_t         pre_e;
  logic              stop_hit;
  logic              busy;
  logic [3:0]        idx;
  logic [BA_W-1:0]   ba_q;
  logic [ADDR_W-1:0] col_q;
  logic              ap_q;
  logic [W-1:0]      dq_q;
  logic              dqs_q;
  logic              oe;
  // Column of element i, wrapping inside the burst-aligned block
  function automatic logic [ADDR_W-1:0] col_at(input logic [ADDR_W-1:0] c,
                                               input logic [3:0] i, input logic [3:0] m);
    col_at = {c[ADDR_W-1:4], (c[3:0] & ~m) | ((c[3:0] + i) & m)};
  endfunction
  // Read data is a fixed pattern of bank, row and column
  function automatic logic [W-1:0] pat(input logic [BA_W-1:0] b,
                                       input logic [ADDR_W-1:0] r, input logic [ADDR_W-1:0] c);
    pat = W'({b, r[5:0], c[7:0]});
  endfunction
  assign bl   = bl_len(bl_sel);
  assign mask = 4'(bl - 5'h01);
  // ********************************
  // Pin synchronisers and edge finding
  // ********************************
  // Clock and command share one chain so they stay aligned
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= '0;
      sync2 <= '0;
      ck_d  <= 1'b0;
    end else begin
      sync1 <= {link.ck, link.cmd, link.ba, link.addr};
      sync2 <= sync1;
      ck_d  <= sync2[SW-1];
    end
  end
  assign ck_s   = sync2[SW-1];
  assign rise   = ck_s & ~ck_d;
  assign fall   = ~ck_s & ck_d;
  assign cmd_s  = lpar_cmd_t'(sync2[SW-2 -: 3]);
  assign ba_s   = sync2[ADDR_W +: BA_W];
  assign addr_s = sync2[ADDR_W-1:0];
  // ********************************
  // Bank state; spacing counters read one less than periods elapsed
  // ********************************
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic              open;
    logic [ADDR_W-1:0] row;
    logic [CNT_W-1:0]  sa;
    logic [CNT_W-1:0]  sp;
    logic              apw;
    logic [4:0]        apc;
    logic              err;
    logic              hit;
    assign hit = ba_s == BA_W'(b);
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        open <= 1'b0;
        row  <= '0;
        sa   <= CNT_RST;
        sp   <= CNT_RST;
        apw  <= 1'b0;
        apc  <= '0;
        err  <= 1'b0;
      end else if (rise) begin
        sa <= (&sa) ? sa : sa + 1'b1;
        sp <= (&sp) ? sp : sp + 1'b1;
        // Auto-precharge waits for half a burst and the active minimum
        if (apw) begin
          if (apc > 5'h01) begin
            apc <= apc - 5'h01;
          end else if (sa >= CNT_W'(RAS)) begin
            apw  <= 1'b0;
            open <= 1'b0;
            sp   <= '0;
          end
        end
        case (cmd_s)
          CMD_ACT: begin
            if (hit) begin
              err  <= err | open | (sa < CNT_W'(RC - 1)) | (sp < CNT_W'(RP - 1))
                      | (rrd < CNT_W'(RRD - 1));
              open <= 1'b1;
              row  <= addr_s;
              sa   <= '0;
            end
          end
          CMD_READ: begin
            if (hit) begin
              err <= err | ~open | (sa < CNT_W'(RCD - 1));
              if (addr_s[AP_BIT]) begin
                apw <= 1'b1;
                apc <= bl >> 1;
              end
            end
          end
          CMD_PRE: begin
            if (hit | addr_s[AP_BIT]) begin
              open <= 1'b0;
              sp   <= '0;
              apw  <= 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    assign bk_row[b]    = row;
    assign bk_err[b]    = err;
    assign bank_open[b] = open;
  end
  // Activate-to-activate spacing across banks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rrd <= CNT_RST;
    end else if (rise) begin
      rrd <= (cmd_s == CMD_ACT) ? '0 : ((&rrd) ? rrd : rrd + 1'b1);
    end
  end
  // ********************************
  // Read latency pipeline
  // ********************************
  // Reads and every burst-ending command share one delay, so a stop
  // lands exactly after the pairs counted from its read
  always_comb begin
    cur     = '0;
    cur.v   = rise & ((cmd_s == CMD_READ) | (cmd_s == CMD_BURST_STOP)
              | (cmd_s == CMD_WRITE) | (cmd_s == CMD_PRE));
    cur.rd  = cmd_s == CMD_READ;
    cur.ap  = addr_s[AP_BIT];
    cur.any = (cmd_s != CMD_PRE) | addr_s[AP_BIT];
    cur.ba  = ba_s;
    cur.col = addr_s;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dl1 <= '0;
      dl2 <= '0;
    end else if (rise) begin
      dl1 <= cur;
      dl2 <= dl1;
    end
  end
  // Latency select; the preamble stage sits one cycle earlier
  assign st_e     = (cas_lat == CL3) ? dl2 : dl1;
  assign pre_e    = (cas_lat == CL3) ? dl1 : cur;
  assign stop_hit = st_e.v & ~st_e.rd & (st_e.any | (st_e.ba == ba_q));
  // ********************************
  // Burst output engine
  // ********************************
  // A new read always wins over the running burst, which gives both
  // seamless concatenation and truncation from one path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy      <= 1'b0;
      idx       <= '0;
      ba_q      <= '0;
      col_q     <= '0;
      ap_q      <= 1'b0;
      dq_q      <= '0;
      dqs_q     <= 1'b0;
      oe        <= 1'b0;
    end else if (rise | fall) begin
      if (rise & st_e.v & st_e.rd) begin
        busy  <= 1'b1;
        idx   <= '0;
        ba_q  <= st_e.ba;
        col_q <= st_e.col;
        ap_q  <= st_e.ap;
        dq_q  <= pat(st_e.ba, bk_row[st_e.ba], st_e.col);
        dqs_q <= 1'b1;
        oe    <= 1'b1;
      end else if (busy & ((rise & stop_hit & ~ap_q) | (idx == mask))) begin
        busy  <= 1'b0;
        dqs_q <= 1'b0;
        oe    <= rise & pre_e.v & pre_e.rd;
      end else if (busy) begin
        idx   <= idx + 4'h1;
        dq_q  <= pat(ba_q, bk_row[ba_q], col_at(col_q, idx + 4'h1, mask));
        dqs_q <= ~dqs_q;
      end else if (rise) begin
        dqs_q <= 1'b0;
        oe    <= pre_e.v & pre_e.rd;
      end
    end
  end
  // Sticky protocol error; a stop, write or precharge cannot cut an auto-precharge burst, so one that hits it is flagged
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      proto_err <= 1'b0;
    end else begin
      proto_err <= proto_err | (|bk_err) | (rise & busy & stop_hit & ap_q);
    end
  end
  // ********************************
  // Pins, one strobe per byte lane
  // ********************************
  assign link.dq_out = dq_q;
  assign link.dq_oe  = oe;
  for (genvar i = 0; i < NB; i++) begin : g_lane
    assign link.dqs_out[i] = dqs_q;
    assign link.dqs_oe[i]  = oe;
  end
endmodule // lpar_dev

//--- tb/lpar_props.sv
`timescale 1ns/1ps
// ********************************
// Link protocol checker
// ********************************
module lpar_props import lpar_pkg::*; #(
  parameter int RCD = T_RCD,
  parameter int RC  = T_RC,
  parameter int RRD = T_RRD
) (
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic            ck,
  input wire lpar_cmd_t       cmd,
  input wire logic [BA_W-1:0] ba,
  input wire logic            dq_oe,
  input wire logic [1:0]      dqs_oe,
  input wire logic [1:0]      dqs
);
  logic       ck_q;
  logic       rise;
  logic [7:0] age [NBANK];
  logic [7:0] g_age;
  logic [7:0] rd_age;
  logic [7:0] st_age;

  function automatic logic [7:0] sat(input logic [7:0] v);
    sat = (v == 8'hff) ? v : v + 8'h01;
  endfunction

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Link clock edge as the memory end would see it
  assign rise = ck & ~ck_q;
  always_ff @(posedge clk) begin
    ck_q <= sys_rst ? 1'b0 : ck;
  end

  // Link rises since the last activate, per bank and overall
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int b = 0; b < NBANK; b++) age[b] <= 8'hff;
      g_age <= 8'hff;
    end else if (rise) begin
      for (int b = 0; b < NBANK; b++)
        age[b] <= (cmd == CMD_ACT && ba == b[BA_W-1:0]) ? 8'h00 : sat(age[b]);
      g_age <= (cmd == CMD_ACT) ? 8'h00 : sat(g_age);
    end
  end

  // Clk counts since the last read and last stop or precharge; saturate, never wrap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_age <= 8'hff;
      st_age <= 8'hff;
    end else begin
      rd_age <= (rise && cmd == CMD_READ) ? 8'h00 : sat(rd_age);
      st_age <= (rise && (cmd == CMD_BURST_STOP || cmd == CMD_PRE)) ? 8'h00 : sat(st_age);
    end
  end

  a_ck_half: assert property ($rose(ck) |-> ck[*4] ##1 !ck)
    else $error("link clock half period wrong");
  a_cmd_held: assert property (ck && ck_q |-> $stable(cmd) && $stable(ba))
    else $error("command moved while link clock high");
  a_rcd_gap: assert property (rise && cmd == CMD_READ |-> age[ba] >= RCD - 1)
    else $error("read too soon after activate");
  a_rc_gap: assert property (rise && cmd == CMD_ACT |-> age[ba] >= RC - 1)
    else $error("same bank activates too close");
  a_rrd_gap: assert property (rise && cmd == CMD_ACT |-> g_age >= RRD - 1)
    else $error("activates too close");
  a_pre_low: assert property ($rose(dq_oe) |-> (dqs == 2'h0)[*6])
    else $error("strobe not low in preamble");
  a_first_edge: assert property ($rose(dq_oe) |-> ##[4:12] dqs[0])
    else $error("strobe did not rise after preamble");
  a_post_low: assert property ($fell(dq_oe) |-> $past(dqs) == 2'h0)
    else $error("strobe not low in last element");
  a_lanes_same: assert property (dqs_oe[0] == dqs_oe[1] && dqs[0] == dqs[1])
    else $error("byte strobes differ");
  a_read_out: assert property (rise && cmd == CMD_READ |-> ##[2:32] dq_oe)
    else $error("no read data after latency");
  a_release: assert property (dq_oe |-> rd_age <= 8'h60)
    else $error("data pins not released");
  a_stop_cut: assert property (dq_oe && st_age < rd_age |-> st_age <= 8'h2c)
    else $error("burst not cut by stop");
endmodule // lpar_props

//--- tb/tb_top.sv
`timescale 1ns/1ps
// ********************************
// Controller and memory end to end
// ********************************
module tb_top import lpar_pkg::*;;
  logic              clk, sys_rst, req_valid, req_ready, req_reject, rj;
  logic              rd_valid, rd_ready, rd_overrun, proto_err;
  logic [1:0]        cas_lat, bl_sel;
  lpar_cmd_t         req_cmd;
  logic [BA_W-1:0]   req_ba;
  logic [ADDR_W-1:0] req_addr;
  logic [2*DQ_W-1:0] rd_data;
  logic [NBANK-1:0]  bank_open;
  int                error_cnt, n_checks;

  lpar_if link ();
  lpar_ctl i_lpar_ctl (.clk, .sys_rst, .cas_lat, .bl_sel, .req_valid, .req_ready,
    .req_cmd, .req_ba, .req_addr, .req_reject, .rd_valid, .rd_ready, .rd_data,
    .rd_overrun, .link(link));
  lpar_dev i_lpar_dev (.clk, .sys_rst, .cas_lat, .bl_sel, .link(link), .bank_open,
    .proto_err);
  lpar_props #(.RCD(T_RCD), .RC(T_RC), .RRD(T_RRD)) i_lpar_props (.clk, .sys_rst,
    .ck(link.ck), .cmd(link.cmd), .ba(link.ba), .dq_oe(link.dq_oe),
    .dqs_oe(link.dqs_oe), .dqs(link.dqs));

  // Free running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Latency and length only change under reset
  task automatic do_reset(input logic [1:0] cl, input logic [1:0] bl);
    @(posedge clk);
    sys_rst <= 1'b1;
    cas_lat <= cl;
    bl_sel  <= bl;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  // Request held until the taking edge; ready sampled half a clock early
  task automatic issue(input lpar_cmd_t c, input logic [1:0] b, input logic [12:0] a);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_ba    <= b;
    req_addr  <= a;
    n = 0;
    do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 400);
    if (n >= 400) begin error_cnt++; close_out; end
    rj = req_reject;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  // Column of element k inside its wrapped burst
  function automatic logic [7:0] colk(input logic [12:0] col, input int k, input int bl);
    logic [12:0] m;
    m = 13'(bl - 1);
    colk = 8'((col & ~m) | ((col + 13'(k)) & m));
  endfunction

  // Pops pairs one by one; the bench is a slow reader on purpose
  task automatic pull(input logic [1:0] b, input logic [5:0] r, input logic [12:0] col,
                      input int bl, input int pairs);
    int n;
    for (int j = 0; j < pairs; j++) begin
      n = 0;
      do begin @(negedge clk); n++; end while (rd_valid !== 1'b1 && n < 300);
      if (n >= 300) begin error_cnt++; close_out; end
      chk(rd_data, {b, r, colk(col, 2*j+1, bl), b, r, colk(col, 2*j, bl)});
      @(posedge clk) rd_ready <= 1'b1;
      @(posedge clk) rd_ready <= 1'b0;
    end
  endtask

  task automatic see_open(input logic [3:0] m);
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (bank_open !== m && n < 300);
    chk(bank_open, m);
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1; cas_lat = 2'h3; bl_sel = 2'h1; req_valid = 1'b0; rd_ready = 1'b0;
    req_cmd = CMD_NOP; req_ba = 2'h0; req_addr = 13'h0; error_cnt = 0; n_checks = 0;
    // Every burst length, both latencies
    for (int i = 0; i < 4; i++) begin
      do_reset(2'(2 + i % 2), 2'(i));
      issue(CMD_ACT, 2'h1, 13'h3);
      issue(CMD_READ, 2'h1, 13'h3);
      pull(2'h1, 6'h3, 13'h3, 2 << i, 1 << i);
    end
    do_reset(2'h3, 2'h1);
    issue(CMD_READ, 2'h1, 13'h0);
    chk(rj, 1'b1);
    issue(CMD_ACT, 2'h0, 13'h5);
    see_open(4'h1);
    issue(CMD_READ, 2'h0, 13'h4);
    repeat (40) @(posedge clk);
    pull(2'h0, 6'h5, 13'h4, 4, 2);
    // Reads one period apart cut the first burst to one pair
    issue(CMD_READ, 2'h0, 13'h8);
    issue(CMD_READ, 2'h0, 13'hc);
    pull(2'h0, 6'h5, 13'h8, 4, 1);
    pull(2'h0, 6'h5, 13'hc, 4, 2);
    // Two periods apart the bursts join without a gap
    issue(CMD_READ, 2'h0, 13'h0);
    issue(CMD_NOP, 2'h0, 13'h0);
    issue(CMD_READ, 2'h0, 13'h4);
    pull(2'h0, 6'h5, 13'h0, 4, 2);
    pull(2'h0, 6'h5, 13'h4, 4, 2);
    issue(CMD_READ, 2'h0, 13'h0);
    issue(CMD_BURST_STOP, 2'h0, 13'h0);
    pull(2'h0, 6'h5, 13'h0, 4, 1);
    repeat (60) @(posedge clk);
    chk(rd_valid, 1'b0);
    issue(CMD_PRE, 2'h0, 13'h0);
    see_open(4'h0);
    issue(CMD_ACT, 2'h2, 13'h7);
    issue(CMD_ACT, 2'h3, 13'h9);
    see_open(4'hc);
    // Auto-precharge read closes its bank by itself
    issue(CMD_READ, 2'h2, 13'h402);
    pull(2'h2, 6'h7, 13'h402, 4, 2);
    see_open(4'h8);
    // A write is held back until the read burst has drained whole
    issue(CMD_READ, 2'h3, 13'h0);
    issue(CMD_WRITE, 2'h3, 13'h0);
    pull(2'h3, 6'h9, 13'h0, 4, 2);
    chk(proto_err, 1'b0);
    chk(rd_overrun, 1'b0);
    close_out;
  end
endmodule // tb_top
